// ===== verilog/line_perf_monitor.sv
module line_perf_monitor #(
    parameter int unsigned TICK_CYCLES_P = line_perf_monitor_pkg::TICK_CYCLES // cycles per second
) (
    input  wire logic                                        clk_sys_i,
    input  wire logic                                        arst_n_i,
    input  wire logic                                        ds1_esf_i,
    input  wire line_perf_monitor_pkg::err_ev_type           ds1_ev_i,
    input  wire line_perf_monitor_pkg::err_ev_type           dsl_ev_i,
    input  wire logic signed [7:0]                           margin_db_i,
    input  wire logic                                        term_rx_i,
    input  wire logic [1:0]                                  hist_sel_i,
    input  wire logic [line_perf_monitor_pkg::HIST_AW-1:0]   hist_idx_i,
    output logic                                             term_tx_o,
    output line_perf_monitor_pkg::screen_type                screen_o,
    output logic [line_perf_monitor_pkg::ELAPSED_W-1:0]      elapsed_o,
    output line_perf_monitor_pkg::perf_cnt_type              ds1_quarter_hour_total_o,
    output line_perf_monitor_pkg::perf_cnt_type              ds1_daily_total_o,
    output line_perf_monitor_pkg::perf_cnt_type              dsl_quarter_hour_total_o,
    output line_perf_monitor_pkg::perf_cnt_type              dsl_daily_total_o,
    output line_perf_monitor_pkg::perf_cnt_type              hist_quarter_o,
    output line_perf_monitor_pkg::perf_cnt_type              hist_daily_o,
    output logic [3:0]                                       margin_o,
    output logic [1:0]                                       view_o,
    output logic                                             loopback_local_o,
    output logic                                             loopback_remote_o,
    output logic                                             selftest_start_o,
    output logic                                             tick_o
);
    localparam int unsigned NPT = 2;   // 0 = ds1, 1 = loop
    localparam int unsigned CW  = line_perf_monitor_pkg::CNT_W;

    // one-second tick divider
    logic [25:0] tick_cnt_reg;
    logic        tick;
    assign tick = (tick_cnt_reg == 26'(TICK_CYCLES_P - 1));
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            tick_cnt_reg <= '0;
            tick_o       <= 1'b0;
        end else begin
            tick_cnt_reg <= tick ? '0 : tick_cnt_reg + 26'h1;
            tick_o       <= tick;
        end
    end

    // terminal receive pin synchroniser, three stages
    logic [2:0] rx_sync_reg;
    logic       rx_level_reg;
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rx_sync_reg  <= 3'h7;
            rx_level_reg <= 1'b1;
        end else begin
            rx_sync_reg <= {rx_sync_reg[1:0], term_rx_i};
            if (rx_sync_reg[1] == rx_sync_reg[2])
                rx_level_reg <= rx_sync_reg[2];
        end
    end

    // receiver: bit period learnt from the leading low run (start bit plus five zero bits) of a space
    logic [15:0] bit_cyc_reg;
    logic        baud_ok_reg;
    logic [15:0] rx_cnt_reg;
    logic [3:0]  rx_bit_reg;
    logic [7:0]  rx_shift_reg;
    logic        rx_busy_reg;
    logic        rx_meas_reg;
    logic        rx_valid_reg;
    logic [7:0]  rx_data_reg;
    logic [1:0]  space_cnt_reg;
    logic        rx_skip_reg;
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            bit_cyc_reg   <= '0;
            baud_ok_reg   <= 1'b0;
            rx_cnt_reg    <= '0;
            rx_bit_reg    <= '0;
            rx_shift_reg  <= '0;
            rx_busy_reg   <= 1'b0;
            rx_meas_reg   <= 1'b0;
            rx_valid_reg  <= 1'b0;
            rx_data_reg   <= '0;
            rx_skip_reg   <= 1'b0;
            space_cnt_reg <= '0;
        end else begin
            rx_valid_reg <= 1'b0;
            if (!baud_ok_reg) begin
                // a space is start bit plus five zero bits: measure the low run / 6
                if (!rx_meas_reg && !rx_level_reg) begin
                    rx_meas_reg <= 1'b1;
                    rx_cnt_reg  <= '0;
                end else if (rx_meas_reg && !rx_level_reg) begin
                    if (rx_cnt_reg != 16'hffff)
                        rx_cnt_reg <= rx_cnt_reg + 16'h1;
                end else if (rx_meas_reg && rx_skip_reg) begin
                    // trailing zero bits of the same space: character over, line at stop
                    rx_meas_reg <= 1'b0;
                    rx_skip_reg <= 1'b0;
                    if (space_cnt_reg == 2'(line_perf_monitor_pkg::SPACES_NEEDED))
                        baud_ok_reg <= 1'b1;
                end else if (rx_meas_reg) begin
                    rx_meas_reg <= 1'b0;
                    // bit period vs MAX_BAUD_CYCLES; the saturating count / 6 never exceeds it, so every rate is accepted
                    if (rx_cnt_reg / 16'h6 <= 16'(line_perf_monitor_pkg::MAX_BAUD_CYCLES)) begin
                        bit_cyc_reg   <= rx_cnt_reg / 16'h6;
                        space_cnt_reg <= space_cnt_reg + 2'h1;
                        rx_skip_reg   <= 1'b1; // next low run is the top bits of this space
                    end else begin
                        space_cnt_reg <= '0;
                    end
                end
            end else if (!rx_busy_reg) begin
                if (!rx_level_reg) begin
                    rx_busy_reg <= 1'b1;
                    rx_cnt_reg  <= bit_cyc_reg >> 1;
                    rx_bit_reg  <= '0;
                end
            end else if (rx_cnt_reg == bit_cyc_reg) begin
                rx_cnt_reg <= '0;
                rx_bit_reg <= rx_bit_reg + 4'h1;
                if (rx_bit_reg >= 4'h1 && rx_bit_reg <= 4'(line_perf_monitor_pkg::DATA_BITS))
                    rx_shift_reg <= {rx_level_reg, rx_shift_reg[7:1]};
                if (rx_bit_reg == 4'(line_perf_monitor_pkg::DATA_BITS + 1)) begin
                    rx_busy_reg  <= 1'b0;
                    rx_valid_reg <= rx_level_reg; // stop bit must be high
                    rx_data_reg  <= rx_shift_reg;
                end
            end else begin
                rx_cnt_reg <= rx_cnt_reg + 16'h1;
            end
        end
    end

    // menu navigation
    logic zero_req;
    assign zero_req = rx_valid_reg && screen_o == line_perf_monitor_pkg::SCR_STATUS
                      && rx_data_reg == line_perf_monitor_pkg::CH_Z;
    logic [7:0] tx_char_next;
    logic       tx_req_next;
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            screen_o          <= line_perf_monitor_pkg::SCR_NONE;
            view_o            <= '0;
            loopback_local_o  <= 1'b0;
            loopback_remote_o <= 1'b0;
            selftest_start_o  <= 1'b0;
        end else begin
            selftest_start_o <= 1'b0;
            if (screen_o == line_perf_monitor_pkg::SCR_NONE && baud_ok_reg)
                screen_o <= line_perf_monitor_pkg::SCR_INTRO;
            else if (rx_valid_reg) begin
                case (screen_o)
                    line_perf_monitor_pkg::SCR_INTRO:
                        screen_o <= line_perf_monitor_pkg::SCR_MAIN;
                    line_perf_monitor_pkg::SCR_MAIN: begin
                        if (rx_data_reg >= line_perf_monitor_pkg::CH_ONE
                            && rx_data_reg <= line_perf_monitor_pkg::CH_SEVEN)
                            screen_o <= line_perf_monitor_pkg::screen_type'(
                                4'(rx_data_reg - line_perf_monitor_pkg::CH_ZERO) + 4'h2);
                    end
                    line_perf_monitor_pkg::SCR_HISTORY: begin
                        if (rx_data_reg >= line_perf_monitor_pkg::CH_ONE
                            && rx_data_reg <= line_perf_monitor_pkg::CH_ONE + 8'h1)
                            view_o <= 2'(rx_data_reg - line_perf_monitor_pkg::CH_ONE);
                        else if (rx_data_reg == line_perf_monitor_pkg::CH_M)
                            screen_o <= line_perf_monitor_pkg::SCR_MAIN;
                    end
                    line_perf_monitor_pkg::SCR_LOOPBACK: begin
                        if (rx_data_reg == line_perf_monitor_pkg::CH_L)
                            loopback_local_o <= ~loopback_local_o;
                        else if (rx_data_reg == line_perf_monitor_pkg::CH_E)
                            loopback_remote_o <= ~loopback_remote_o;
                        else if (rx_data_reg == line_perf_monitor_pkg::CH_M)
                            screen_o <= line_perf_monitor_pkg::SCR_MAIN;
                    end
                    line_perf_monitor_pkg::SCR_SELFTEST: begin
                        if (rx_data_reg == line_perf_monitor_pkg::CH_S)
                            selftest_start_o <= 1'b1;
                        else if (rx_data_reg == line_perf_monitor_pkg::CH_M)
                            screen_o <= line_perf_monitor_pkg::SCR_MAIN;
                    end
                    default: begin
                        if (rx_data_reg == line_perf_monitor_pkg::CH_M)
                            screen_o <= line_perf_monitor_pkg::SCR_MAIN;
                    end
                endcase
            end
        end
    end

    // echo: screen code or loopback state digit sent after each accepted char
    always_comb begin
        tx_req_next  = rx_valid_reg || (screen_o == line_perf_monitor_pkg::SCR_NONE
                                        && baud_ok_reg);
        tx_char_next = line_perf_monitor_pkg::CH_ZERO + 8'(screen_o);
        if (screen_o == line_perf_monitor_pkg::SCR_LOOPBACK)
            tx_char_next = line_perf_monitor_pkg::CH_ZERO
                           + {6'h0, loopback_remote_o, loopback_local_o};
    end

    // transmitter, same learnt bit period, 8n1
    logic [9:0]  tx_shift_reg;
    logic [3:0]  tx_bit_reg;
    logic [15:0] tx_cnt_reg;
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            tx_shift_reg <= '1;
            tx_bit_reg   <= '0;
            tx_cnt_reg   <= '0;
            term_tx_o    <= 1'b1;
        end else if (tx_bit_reg == 4'h0) begin
            term_tx_o <= 1'b1;
            if (tx_req_next) begin
                tx_shift_reg <= {1'b1, tx_char_next, 1'b0};
                tx_bit_reg   <= 4'(line_perf_monitor_pkg::DATA_BITS + 2);
                tx_cnt_reg   <= '0;
            end
        end else if (tx_cnt_reg == 16'h0) begin
            term_tx_o    <= tx_shift_reg[0];
            tx_shift_reg <= {1'b1, tx_shift_reg[9:1]};
            tx_cnt_reg   <= bit_cyc_reg;
            tx_bit_reg   <= tx_bit_reg - 4'h1;
        end else begin
            tx_cnt_reg <= tx_cnt_reg - 16'h1;
        end
    end

    // boundaries: elapsed seconds, quarter hour, day
    logic [9:0] sec_in_q_reg;
    logic [6:0] q_in_day_reg;
    logic       q_end;
    logic       d_end;
    assign q_end = tick && sec_in_q_reg == 10'(line_perf_monitor_pkg::QUARTER_S - 1);
    assign d_end = q_end && q_in_day_reg == 7'(line_perf_monitor_pkg::DAY_QUARTERS - 1);
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            elapsed_o    <= '0;
            sec_in_q_reg <= '0;
            q_in_day_reg <= '0;
        end else if (zero_req) begin
            elapsed_o    <= '0;
            sec_in_q_reg <= '0;
            q_in_day_reg <= '0;
        end else if (tick) begin
            elapsed_o    <= elapsed_o + 32'h1;
            sec_in_q_reg <= q_end ? '0 : sec_in_q_reg + 10'h1;
            if (q_end)
                q_in_day_reg <= d_end ? '0 : q_in_day_reg + 7'h1;
        end
    end

    // per point error classification and accumulation
    line_perf_monitor_pkg::perf_cnt_type quarter_reg [NPT];
    line_perf_monitor_pkg::perf_cnt_type day_reg     [NPT];
    line_perf_monitor_pkg::perf_cnt_type hist_q_mem  [NPT][line_perf_monitor_pkg::HIST_DEPTH];
    line_perf_monitor_pkg::perf_cnt_type hist_d_reg  [NPT];
    logic [4:0] wr_ptr_reg;
    genvar gp;
    generate
        for (gp = 0; gp < NPT; gp++) begin : g_pt
            line_perf_monitor_pkg::err_ev_type ev;
            logic [15:0] bpv_reg;
            logic [15:0] aux_reg;
            logic        los_reg;
            logic        es_sec;
            logic        ses_sec;
            assign ev = (gp == 0) ? ds1_ev_i : dsl_ev_i;
            // error of the current second, closed on the tick
            always_comb begin
                if (gp == 1) begin
                    es_sec  = aux_reg != '0;
                    ses_sec = aux_reg >= line_perf_monitor_pkg::DSL_CRC_SEVERE;
                end else if (ds1_esf_i) begin
                    es_sec  = bpv_reg != '0 || aux_reg != '0;
                    ses_sec = bpv_reg >= line_perf_monitor_pkg::ESF_BPV_SEVERE
                              || aux_reg >= line_perf_monitor_pkg::ESF_CRC_SEVERE;
                end else begin
                    es_sec  = bpv_reg != '0 || aux_reg != '0;
                    ses_sec = bpv_reg >= line_perf_monitor_pkg::SF_BPV_SEVERE
                              || aux_reg >= line_perf_monitor_pkg::SF_FBE_SEVERE;
                end
            end
            // event counters within the second, saturating
            always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
                if (!arst_n_i) begin
                    bpv_reg <= '0;
                    aux_reg <= '0;
                    los_reg <= 1'b0;
                end else if (tick) begin
                    bpv_reg <= '0;
                    aux_reg <= '0;
                    los_reg <= 1'b0;
                end else begin
                    if (gp == 0 && ev.bipolar_violation && bpv_reg != 16'hffff)
                        bpv_reg <= bpv_reg + 16'h1;
                    if (((gp == 0 && !ds1_esf_i) ? ev.fbe : ev.crc) && aux_reg != 16'hffff)
                        aux_reg <= aux_reg + 16'h1;
                    if (ev.los || ev.lsync)
                        los_reg <= 1'b1;
                end
            end
            // totals, history store and zeroing
            always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
                if (!arst_n_i) begin
                    quarter_reg[gp] <= '0;
                    day_reg[gp]     <= '0;
                    hist_d_reg[gp]  <= '0;
                end else if (zero_req) begin
                    quarter_reg[gp] <= '0;
                    day_reg[gp]     <= '0;
                    hist_d_reg[gp]  <= '0;
                end else if (tick) begin
                    quarter_reg[gp] <= q_end ? '0 : quarter_reg[gp]
                        + {CW'(es_sec), CW'(ses_sec), CW'(los_reg)};
                    day_reg[gp] <= d_end ? '0 : day_reg[gp]
                        + {CW'(es_sec), CW'(ses_sec), CW'(los_reg)};
                    if (d_end)
                        hist_d_reg[gp] <= day_reg[gp];
                end
            end
            // quarter-hour history ring, oldest overwritten
            always_ff @(posedge clk_sys_i) begin
                if (q_end && !zero_req)
                    hist_q_mem[gp][wr_ptr_reg] <= quarter_reg[gp];
            end
        end
    endgenerate

    // ring pointer and valid count for history
    logic [5:0] hist_fill_reg;
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wr_ptr_reg    <= '0;
            hist_fill_reg <= '0;
        end else if (zero_req) begin
            wr_ptr_reg    <= '0;
            hist_fill_reg <= '0;
        end else if (q_end) begin
            wr_ptr_reg <= wr_ptr_reg + 5'h1;
            if (hist_fill_reg != 6'(line_perf_monitor_pkg::HIST_DEPTH))
                hist_fill_reg <= hist_fill_reg + 6'h1;
        end
    end

    // reported totals, history readout and margin
    logic [4:0] rd_ptr;
    logic       pt_sel;
    assign rd_ptr = wr_ptr_reg - 5'h1 - hist_idx_i;
    assign pt_sel = hist_sel_i[0];
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ds1_quarter_hour_total_o <= '0;
            ds1_daily_total_o        <= '0;
            dsl_quarter_hour_total_o <= '0;
            dsl_daily_total_o        <= '0;
            hist_quarter_o           <= '0;
            hist_daily_o             <= '0;
            margin_o                 <= '0;
        end else begin
            ds1_quarter_hour_total_o <= quarter_reg[0];
            ds1_daily_total_o        <= day_reg[0];
            dsl_quarter_hour_total_o <= quarter_reg[1];
            dsl_daily_total_o        <= day_reg[1];
            hist_daily_o             <= hist_d_reg[pt_sel];
            hist_quarter_o <= ({1'b0, hist_idx_i} < hist_fill_reg)
                              ? hist_q_mem[pt_sel][rd_ptr] : '0;
            if (margin_db_i <= 8'sh0)
                margin_o <= 4'h0;
            else if (margin_db_i >= 8'sh9)
                margin_o <= line_perf_monitor_pkg::MARGIN_MAX;
            else
                margin_o <= margin_db_i[3:0];
        end
    end

    // checks
    property p_margin_clamp;
        @(posedge clk_sys_i) disable iff (!arst_n_i)
        margin_db_i >= 8'sh9 |=> margin_o == line_perf_monitor_pkg::MARGIN_MAX;
    endproperty
    a_margin_clamp: assert property (p_margin_clamp)
        else $error("margin not clamped to nine");
    property p_zero_clears;
        @(posedge clk_sys_i) disable iff (!arst_n_i)
        zero_req |=> day_reg[0] == '0 && hist_d_reg[1] == '0;
    endproperty
    a_zero_clears: assert property (p_zero_clears)
        else $error("clear did not zero counts");
    property p_dsl_severe;
        @(posedge clk_sys_i) disable iff (!arst_n_i)
        tick && !q_end && !zero_req
        && g_pt[1].aux_reg >= line_perf_monitor_pkg::DSL_CRC_SEVERE
        |=> day_reg[1].severe_error_second_count == $past(day_reg[1].severe_error_second_count) + CW'(1);
    endproperty
    a_dsl_severe: assert property (p_dsl_severe)
        else $error("loop severe second missed");
    property p_dsl_errored;
        @(posedge clk_sys_i) disable iff (!arst_n_i)
        tick && !q_end && !zero_req && g_pt[1].aux_reg != '0
        |=> day_reg[1].es == $past(day_reg[1].es) + CW'(1);
    endproperty
    a_dsl_errored: assert property (p_dsl_errored)
        else $error("loop errored second missed");
    property p_ds1_unavail;
        @(posedge clk_sys_i) disable iff (!arst_n_i)
        tick && !q_end && !zero_req && g_pt[0].los_reg
        |=> day_reg[0].unavailable_second_count == $past(day_reg[0].unavailable_second_count) + CW'(1);
    endproperty
    a_ds1_unavail: assert property (p_ds1_unavail)
        else $error("ds1 unavailable second missed");
    property p_elapsed_step;
        @(posedge clk_sys_i) disable iff (!arst_n_i)
        tick && !zero_req |=> elapsed_o == $past(elapsed_o) + 32'h1;
    endproperty
    a_elapsed_step: assert property (p_elapsed_step)
        else $error("elapsed time did not advance");
    c_intro: cover property (@(posedge clk_sys_i) screen_o == line_perf_monitor_pkg::SCR_INTRO);
    c_quarter: cover property (@(posedge clk_sys_i) q_end);
    c_zero: cover property (@(posedge clk_sys_i) zero_req);
endmodule // line_perf_monitor

// ===== verilog/line_perf_monitor_pkg.sv
package line_perf_monitor_pkg;
    // clock and time base
    localparam int unsigned CLK_HZ          = 50000000;
    localparam int unsigned TICK_S          = 1;
    localparam int unsigned TICK_CYCLES     = CLK_HZ * TICK_S;
    localparam int unsigned QUARTER_S       = 900;
    localparam int unsigned DAY_QUARTERS    = 96;
    // severe error thresholds
    localparam logic [15:0] SF_BPV_SEVERE   = 16'd1554;
    localparam logic [15:0] SF_FBE_SEVERE   = 16'd8;
    localparam logic [15:0] ESF_BPV_SEVERE  = 16'd1544;
    localparam logic [15:0] ESF_CRC_SEVERE  = 16'd320;
    localparam logic [15:0] DSL_CRC_SEVERE  = 16'd165;
    // counter widths and history depth
    localparam int unsigned CNT_W           = 17;
    localparam int unsigned HIST_DEPTH      = 32;
    localparam int unsigned HIST_AW         = 5;
    localparam int unsigned ELAPSED_W       = 32;
    localparam logic [3:0]  MARGIN_MAX      = 4'h9;
    // terminal link
    localparam int unsigned MIN_BAUD        = 2400;
    localparam int unsigned MAX_BAUD_CYCLES = CLK_HZ / MIN_BAUD;
    localparam int unsigned BAUD_W          = 16;
    localparam int unsigned DATA_BITS       = 8;
    localparam int unsigned SPACES_NEEDED   = 3;
    // characters
    localparam logic [7:0] CH_SPACE = 8'h20;
    localparam logic [7:0] CH_ZERO  = 8'h30;
    localparam logic [7:0] CH_ONE   = 8'h31;
    localparam logic [7:0] CH_SEVEN = 8'h37;
    localparam logic [7:0] CH_M     = 8'h4d;
    localparam logic [7:0] CH_Z     = 8'h5a;
    localparam logic [7:0] CH_S     = 8'h53;
    localparam logic [7:0] CH_L     = 8'h4c;
    localparam logic [7:0] CH_E     = 8'h45;
    localparam logic [7:0] CH_QMARK = 8'h3f;

    typedef enum logic [3:0] {
        SCR_NONE, SCR_INTRO, SCR_MAIN, SCR_STATUS, SCR_HISTORY,
        SCR_VENDOR, SCR_LOOPBACK, SCR_SELFTEST, SCR_PROV, SCR_TROUBLE
    } screen_type;

    // per-second error events of one measurement point
    typedef struct packed {
        logic bipolar_violation;   // bipolar violation (ds1 only)
        logic fbe;   // framing bit error (sf)
        logic crc;   // crc error (esf or loop)
        logic los;   // loss of signal
        logic lsync; // loss of sync
    } err_ev_type;

    // counts of one measurement point
    typedef struct packed {
        logic [CNT_W-1:0] es;
        logic [CNT_W-1:0] severe_error_second_count;
        logic [CNT_W-1:0] unavailable_second_count;
    } perf_cnt_type;
endpackage

// ===== dv/term_model.sv
// craft terminal sending 8n1 characters, lsb first
module term_model #(
    parameter int BIT_CYC = 2604
) (
    input  wire logic clk_sys_i,
    input  wire logic tx_line_i,
    output logic      rx_line_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // line rests at mark between characters
    initial rx_line_o = 1'b1;
    // start bit, data lsb first, one stop bit
    task automatic send_char(input logic [7:0] ch);
        logic [9:0] frame;
        frame = {1'b1, ch, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(negedge clk_sys_i);
            rx_line_o = frame[i];
            repeat (BIT_CYC - 1) @(negedge clk_sys_i);
        end
    endtask
    // receive one character from the block, sampled mid-bit
    task automatic recv_char(output logic [7:0] ch);
        @(negedge tx_line_i);
        repeat (BIT_CYC / 2) @(negedge clk_sys_i);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT_CYC) @(negedge clk_sys_i);
            ch[i] = tx_line_i;
        end
    endtask
endmodule // term_model

// ===== dv/line_perf_monitor_bench.sv
module line_perf_monitor_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys_i, arst_n_i, term_rx_i, term_tx_o, lb_l, lb_r, tick;
    logic signed [7:0] margin_db_i;
    logic [3:0] margin_o;
    logic [31:0] elapsed_o;
    line_perf_monitor_pkg::screen_type scr;
    line_perf_monitor_pkg::perf_cnt_type q1, d1, q2;
    line_perf_monitor_pkg::err_ev_type ds1_ev, dsl_ev;
    logic [7:0] echo_ch;
    logic [31:0] e0;
    localparam int unsigned SEC_CYC = 400; // short second so counts are reachable
    int err_count, compares;
    int mi[6] = '{-3, 0, 5, 8, 9, 12};
    int mo[6] = '{0, 0, 5, 8, 9, 9};
    line_perf_monitor #(.TICK_CYCLES_P(SEC_CYC)) uut (.clk_sys_i(clk_sys_i),
        .arst_n_i(arst_n_i), .ds1_esf_i(1'b0),
        .ds1_ev_i(ds1_ev), .dsl_ev_i(dsl_ev), .margin_db_i(margin_db_i), .term_rx_i(term_rx_i),
        .hist_sel_i(2'h0), .hist_idx_i('0), .term_tx_o(term_tx_o), .screen_o(scr),
        .elapsed_o(elapsed_o), .ds1_quarter_hour_total_o(q1), .ds1_daily_total_o(d1),
        .dsl_quarter_hour_total_o(q2), .dsl_daily_total_o(), .hist_quarter_o(),
        .hist_daily_o(), .margin_o(margin_o), .view_o(), .loopback_local_o(lb_l),
        .loopback_remote_o(lb_r), .selftest_start_o(), .tick_o(tick));
    term_model term (.clk_sys_i(clk_sys_i), .tx_line_i(term_tx_o), .rx_line_o(term_rx_i));
    // 50 mhz clock
    initial begin
        clk_sys_i = 1'b0;
        forever #10 clk_sys_i = ~clk_sys_i;
    end
    task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string msg);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask
    task automatic chk_scr(input line_perf_monitor_pkg::screen_type exp);
        int n;
        n = 0;
        while (scr !== exp && n < 4000) begin
            @(negedge clk_sys_i);
            n++;
        end
        compares++;
        if (scr !== exp) begin
            err_count++;
            $display("BAD %0t screen %0d exp %0d", $time, scr, exp);
        end
    endtask
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // watchdog for a hung terminal session
    initial begin
        repeat (300000) @(posedge clk_sys_i);
        err_count++;
        $display("BAD %0t watchdog expired", $time);
        final_report();
    end
    // main sequence
    initial begin
        err_count = 0;
        compares = 0;
        arst_n_i = 1'b0;
        margin_db_i = 8'sh00;
        ds1_ev = '0;
        dsl_ev = '0;
        repeat (4) @(negedge clk_sys_i);
        arst_n_i = 1'b1;
        @(negedge clk_sys_i);
        chk(term_tx_o, 1, "tx idle");
        chk(scr, line_perf_monitor_pkg::SCR_NONE, "reset screen");
        chk(64'(q1), 64'h0, "quarter totals at reset");
        chk(64'(d1), 64'h0, "daily totals at reset");
        $display("test reset done");
        for (int i = 0; i < 6; i++) begin
            margin_db_i = 8'(mi[i]);
            repeat (3) @(negedge clk_sys_i);
            chk(margin_o, 64'(mo[i]), "margin clamp");
        end
        $display("test margin done");
        // one second with a loop severe error run and a ds1 error plus loss of signal
        @(negedge clk_sys_i iff tick);
        dsl_ev.crc = 1'b1;
        ds1_ev.bipolar_violation = 1'b1;
        ds1_ev.los = 1'b1;
        @(negedge clk_sys_i);
        ds1_ev = '0;
        repeat (164) @(negedge clk_sys_i);
        dsl_ev.crc = 1'b0;
        @(negedge clk_sys_i iff tick);
        @(negedge clk_sys_i);
        chk(64'(q2), 64'({17'h1, 17'h1, 17'h0}), "loop second counts");
        chk(64'(q1), 64'({17'h1, 17'h0, 17'h1}), "ds1 second counts");
        chk(64'(d1), 64'({17'h1, 17'h0, 17'h1}), "ds1 daily counts");
        e0 = elapsed_o;
        @(negedge clk_sys_i iff tick);
        chk(64'(elapsed_o), 64'(e0 + 32'h1), "elapsed step");
        $display("test seconds done");
        fork
            repeat (3) term.send_char(line_perf_monitor_pkg::CH_SPACE);
            term.recv_char(echo_ch);
        join
        chk_scr(line_perf_monitor_pkg::SCR_INTRO);
        chk(64'(echo_ch), 64'(line_perf_monitor_pkg::CH_ZERO), "intro char");
        term.send_char(line_perf_monitor_pkg::CH_ONE);
        chk_scr(line_perf_monitor_pkg::SCR_MAIN);
        term.send_char(8'h34);
        chk_scr(line_perf_monitor_pkg::SCR_LOOPBACK);
        term.send_char(line_perf_monitor_pkg::CH_L);
        repeat (4000) @(negedge clk_sys_i);
        chk({lb_r, lb_l}, 64'h1, "local loopback");
        chk(64'(elapsed_o >= e0 + 32'd300), 64'h1, "elapsed kept counting");
        $display("test terminal done");
        final_report();
    end
endmodule // line_perf_monitor_bench
